// >>> core/tdpt_top.v
// Purpose: triggered delay pulse timer with output pin routing
// Assumes: camera signals synchronous to clk, AXI4-Lite slave
// Notes: one timer only; count reads the microsecond count of the current phase
`timescale 1ns/1ps
`include "tdpt_regs.vh"
module tdpt_top (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        exposure_window,
   input  wire        readout_window,
   input  wire        external_trigger_input,
   input  wire        counter_output,
   output reg         pin_out,
   output reg         timer_output_source,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   // =====================================================
   // state codes
   localparam S_IDLE  = 2'd0;
   localparam S_ARM   = 2'd1;
   localparam S_DELAY = 2'd2;
   localparam S_PULSE = 2'd3;

   // =====================================================
   // helpers
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   function [25:0] clamp;
      input [31:0] v;
      input [25:0] lo;
      begin
         if (v > {6'h00, `TDPT_TIME_MAX})
            clamp = `TDPT_TIME_MAX;
         else if (v[25:0] < lo)
            clamp = lo;
         else
            clamp = v[25:0];
      end
   endfunction

   // =====================================================
   // configuration registers
   reg         pick_q;
   reg  [2:0]  origin_q;
   reg  [2:0]  cond_q;
   reg  [25:0] delay_q;
   reg  [25:0] length_q;
   reg  [2:0]  pin_sel_q;
   reg         pin_flip_q;
   reg         user_val_q;
   reg         restart_q;

   // =====================================================
   // timer core
   reg  [1:0]  st_q;
   reg  [25:0] cnt_q;
   reg         src_sel;
   wire        tick;
   wire        fire;
   wire        level_on;
   wire        armed = (origin_q != `TDPT_ORG_OFF);

   always @* begin
      case (origin_q)
         `TDPT_ORG_EXPO: src_sel = exposure_window;
         `TDPT_ORG_READ: src_sel = readout_window;
         `TDPT_ORG_EXT:  src_sel = external_trigger_input;
         `TDPT_ORG_CNT:  src_sel = counter_output;
         default:        src_sel = 1'b0;
      endcase
   end

   wire is_level = (cond_q == `TDPT_CND_LUP) || (cond_q == `TDPT_CND_LDN);
   wire start    = is_level ? level_on : fire;

   tdpt_tick u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .clr   (restart_q | (st_q == S_ARM)),
      .tick  (tick)
   );

   tdpt_edge u_edge (
      .clk      (clk),
      .rst_n    (rst_n),
      .src      (src_sel),
      .cond     (cond_q),
      .fire     (fire),
      .level_on (level_on)
   );

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= S_IDLE;
         cnt_q <= 26'd0;
      end else if (restart_q || !armed) begin
         st_q  <= S_IDLE;
         cnt_q <= 26'd0;
      end else begin
         case (st_q)
            S_IDLE: begin
               st_q  <= S_ARM;
               cnt_q <= 26'd0;
            end
            S_ARM: begin
               cnt_q <= 26'd0;
               if (start)
                  st_q <= (delay_q == 26'd0) ? S_PULSE : S_DELAY;
            end
            S_DELAY: begin
               if (is_level && !level_on) begin
                  st_q  <= S_ARM;
                  cnt_q <= 26'd0;
               end else if (tick) begin
                  if (cnt_q + 26'd1 >= delay_q) begin
                     st_q  <= S_PULSE;
                     cnt_q <= 26'd0;
                  end else
                     cnt_q <= cnt_q + 26'd1;
               end
            end
            S_PULSE: begin
               if (is_level) begin
                  if (!level_on) begin
                     st_q  <= S_ARM;
                     cnt_q <= 26'd0;
                  end else if (tick && cnt_q != `TDPT_TIME_MAX)
                     cnt_q <= cnt_q + 26'd1;
               end else if (tick) begin
                  if (cnt_q + 26'd1 >= length_q) begin
                     st_q  <= S_ARM;
                     cnt_q <= 26'd0;
                  end else
                     cnt_q <= cnt_q + 26'd1;
               end
            end
            default: begin
               st_q  <= S_IDLE;
               cnt_q <= 26'd0;
            end
         endcase
      end
   end

   // =====================================================
   // output pin routing
   reg pin_src;
   always @* begin
      case (pin_sel_q)
         `TDPT_PIN_READ:  pin_src = readout_window;
         `TDPT_PIN_EXPO:  pin_src = exposure_window;
         `TDPT_PIN_USER:  pin_src = user_val_q;
         `TDPT_PIN_TIMER: pin_src = (st_q == S_PULSE);
         `TDPT_PIN_CNT:   pin_src = counter_output;
         default:         pin_src = 1'b0;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out             <= 1'b0;
         timer_output_source <= 1'b0;
      end else begin
         // the off choice is also flipped; a flipped idle line rests high
         pin_out             <= pin_src ^ pin_flip_q;
         timer_output_source <= (st_q == S_PULSE);
      end
   end

   // =====================================================
   // state readback
   reg [1:0] state_code;
   always @* begin
      case (st_q)
         S_IDLE:  state_code = `TDPT_ST_IDLE;
         S_ARM:   state_code = `TDPT_ST_WAIT;
         default: state_code = `TDPT_ST_RUN;
      endcase
   end

   // =====================================================
   // AXI4-Lite write channel
   reg [7:0]  aw_q;
   reg        aw_have_q;
   reg [31:0] w_q;
   reg [3:0]  ws_q;
   reg        w_have_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TDPT_RESP_OKAY;
         aw_q          <= 8'h00;
         aw_have_q     <= 1'b0;
         w_q           <= 32'h00000000;
         ws_q          <= 4'h0;
         w_have_q      <= 1'b0;
         pick_q        <= 1'b0;
         origin_q      <= `TDPT_ORG_OFF;
         cond_q        <= `TDPT_CND_EUP;
         delay_q       <= `TDPT_RST_DELAY;
         length_q      <= `TDPT_RST_LENGTH;
         pin_sel_q     <= `TDPT_PIN_OFF;
         pin_flip_q    <= 1'b0;
         user_val_q    <= 1'b0;
         restart_q     <= 1'b0;
      end else begin
         restart_q     <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_have_q && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            aw_q          <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
         end
         if (s_axi_wvalid && !w_have_q && !s_axi_wready && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
            w_q          <= s_axi_wdata;
            ws_q         <= s_axi_wstrb;
            w_have_q     <= 1'b1;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `TDPT_RESP_OKAY;
            case (aw_q)
               `TDPT_OFF_PICK: begin
                  // only timer zero exists; a nonzero low byte is refused
                  if (ws_q[0] && w_q[7:0] != 8'h00)
                     s_axi_bresp <= `TDPT_RESP_SLVERR;
               end
               `TDPT_OFF_ORIGIN: if (ws_q[0]) origin_q <= w_q[2:0];
               `TDPT_OFF_COND:   if (ws_q[0]) cond_q <= w_q[2:0];
               `TDPT_OFF_DELAY:
                  delay_q <= clamp(merge({6'h00, delay_q}, w_q, ws_q), 26'd0);
               `TDPT_OFF_LENGTH:
                  length_q <= clamp(merge({6'h00, length_q}, w_q, ws_q), `TDPT_LENGTH_MIN);
               `TDPT_OFF_RESTART: if (ws_q[0] && w_q[0]) restart_q <= 1'b1;
               `TDPT_OFF_PIN: begin
                  if (ws_q[0]) begin
                     pin_sel_q  <= w_q[`TDPT_PIN_SEL_LSB +: 3];
                     pin_flip_q <= w_q[`TDPT_PIN_FLIP_BIT];
                     user_val_q <= w_q[`TDPT_PIN_USER_BIT];
                  end
               end
               `TDPT_OFF_COUNT, `TDPT_OFF_STATE: ;
               default: s_axi_bresp <= `TDPT_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // =====================================================
   // AXI4-Lite read channel
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `TDPT_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `TDPT_RESP_OKAY;
            case (s_axi_araddr)
               `TDPT_OFF_PICK:    s_axi_rdata <= {31'h0, pick_q};
               `TDPT_OFF_ORIGIN:  s_axi_rdata <= {29'h0, origin_q};
               `TDPT_OFF_COND:    s_axi_rdata <= {29'h0, cond_q};
               `TDPT_OFF_DELAY:   s_axi_rdata <= {6'h00, delay_q};
               `TDPT_OFF_LENGTH:  s_axi_rdata <= {6'h00, length_q};
               `TDPT_OFF_RESTART: s_axi_rdata <= 32'h00000000;
               `TDPT_OFF_COUNT:   s_axi_rdata <= {6'h00, cnt_q};
               `TDPT_OFF_STATE:   s_axi_rdata <= {30'h0, state_code};
               `TDPT_OFF_PIN:     s_axi_rdata <= {26'h0, user_val_q, pin_flip_q, 1'b0, pin_sel_q};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `TDPT_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> shared/tdpt_regs.vh
// Purpose: constants for the triggered delay pulse timer
// Assumes: 125 MHz clock, 32-bit AXI4-Lite register bus
// Notes: offsets are byte addresses of aligned words
// Notes on behaviour
// - output pin follows timer output when pin source select picks the timer
// - exactly one timer, number zero, selectable through timer pick
// - trigger origin off keeps the timer idle always
// - origins: exposure window, readout window, external trigger input, counter output
// - edge modes: pulse lasts programmed length, 1 to 60,000,000 us
// - after trigger wait programmed start delay, 0 to 60,000,000 us
// - restart command clears running state and count then restarts
// - current count readable by software
// - state reported as idle, waiting or running
// - edge up: low-to-high transition triggers
// - edge down: high-to-low transition triggers
// - edge either: any transition triggers
// - level up: output asserted only while source high
// - level down: output asserted only while source low
// - level mode: source applied, delay elapses, then output while source active
// - polarity flip drives complement of selected pin source
`ifndef TDPT_REGS_VH
`define TDPT_REGS_VH
// =====================================================
// register map
`define TDPT_OFF_PICK      8'h00
`define TDPT_OFF_ORIGIN    8'h04
`define TDPT_OFF_COND      8'h08
`define TDPT_OFF_DELAY     8'h0C
`define TDPT_OFF_LENGTH    8'h10
`define TDPT_OFF_RESTART   8'h14
`define TDPT_OFF_COUNT     8'h18
`define TDPT_OFF_STATE     8'h1C
`define TDPT_OFF_PIN       8'h20
// =====================================================
// fields and codes
`define TDPT_ORG_OFF       3'h0
`define TDPT_ORG_EXPO      3'h1
`define TDPT_ORG_READ      3'h2
`define TDPT_ORG_EXT       3'h3
`define TDPT_ORG_CNT       3'h4
`define TDPT_CND_EUP       3'h0
`define TDPT_CND_EDN       3'h1
`define TDPT_CND_EEI       3'h2
`define TDPT_CND_LUP       3'h3
`define TDPT_CND_LDN       3'h4
`define TDPT_ST_IDLE       2'h0
`define TDPT_ST_WAIT       2'h1
`define TDPT_ST_RUN        2'h2
`define TDPT_PIN_OFF       3'h0
`define TDPT_PIN_READ      3'h1
`define TDPT_PIN_EXPO      3'h2
`define TDPT_PIN_USER      3'h3
`define TDPT_PIN_TIMER     3'h4
`define TDPT_PIN_CNT       3'h5
`define TDPT_PIN_SEL_LSB   0
`define TDPT_PIN_FLIP_BIT  4
`define TDPT_PIN_USER_BIT  5
// =====================================================
// limits and reset values
`define TDPT_TIME_MAX      26'd60000000
`define TDPT_LENGTH_MIN    26'd1
`define TDPT_RST_DELAY     26'd0
`define TDPT_RST_LENGTH    26'd1
`define TDPT_RESP_OKAY     2'h0
`define TDPT_RESP_SLVERR   2'h2
// =====================================================
// timing
`define TDPT_CLK_MHZ       125
`define TDPT_TICK_US       1
`define TDPT_TICK_CYC      (`TDPT_CLK_MHZ * `TDPT_TICK_US)
`endif

// >>> core/tdpt_tick.v
// Purpose: one microsecond tick pulse
// Assumes: clk at TDPT_CLK_MHZ
// Notes: restarts with the timer so delays start on a whole microsecond
`timescale 1ns/1ps
`include "tdpt_regs.vh"
module tdpt_tick (
   input  wire clk,
   input  wire rst_n,
   input  wire clr,
   output reg  tick
);
   reg [6:0] cnt_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 7'h00;
         tick  <= 1'b0;
      end else if (clr) begin
         cnt_q <= 7'h00;
         tick  <= 1'b0;
      end else if (cnt_q == (`TDPT_TICK_CYC - 1)) begin
         cnt_q <= 7'h00;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 7'h01;
         tick  <= 1'b0;
      end
   end
endmodule

// >>> core/tdpt_edge.v
// Purpose: trigger detection on the selected source
// Assumes: source already synchronous to clk
// Notes: edges are seen in the same cycle the source moves, against the registered src_q
`timescale 1ns/1ps
`include "tdpt_regs.vh"
module tdpt_edge (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       src,
   input  wire [2:0] cond,
   output wire       fire,
   output wire       level_on
);
   reg src_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         src_q <= 1'b0;
      else
         src_q <= src;
   end
   wire rise = src & ~src_q;
   wire fall = ~src & src_q;
   assign fire = (cond == `TDPT_CND_EUP) ? rise :
                 (cond == `TDPT_CND_EDN) ? fall :
                 (cond == `TDPT_CND_EEI) ? (rise | fall) :
                 1'b0;
   assign level_on = (cond == `TDPT_CND_LUP) ? src :
                     (cond == `TDPT_CND_LDN) ? ~src :
                     1'b0;
endmodule

// >>> test/tdpt_partner.sv
// Purpose: equipment on the camera output line, measures pulses
// Assumes: line sampled on the camera clock
// Notes: only listens; the line has no return path
`timescale 1ns/1ps
module tdpt_partner (
   input  wire clk,
   input  wire line_in,
   output int  width,
   output int  pulses
);
   int run = 0;
   initial width = 0;
   initial pulses = 0;
   // ==========================================
   // pulse width in clock cycles
   always @(posedge clk) begin
      if (line_in === 1'b1) run <= run + 1;
      else if (run != 0) begin
         width <= run;
         pulses <= pulses + 1;
         run <= 0;
      end
   end
endmodule

// >>> test/tdpt_top_props.sv
// Purpose: bus handshake checks on the timer block ports
// Assumes: one clock, asynchronous active low reset
// Notes: timer settings live in registers, so only the bus is judged here
`timescale 1ns/1ps
module tdpt_props (
   input wire        clk,
   input wire        rst_n,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // write side
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   aw_cause_a: assert property (s_axi_awready |-> $past(s_axi_awvalid))
      else $error("awready without request");
   b_after_take_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready) || $past(s_axi_wready))
      else $error("write response without transfer");
   no_take_pending_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
      else $error("bad write response code");
   // ==========================================
   // read side
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
                                  && $stable(s_axi_rresp))
      else $error("read data moved before taken");
   ar_with_r_a: assert property (s_axi_arready |-> $rose(s_axi_rvalid))
      else $error("arready not paired with new read data");
endmodule
bind tdpt_top tdpt_props tdpt_props_inst (
   .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> test/tb_triggered_delay_pulse_timer.sv
// Purpose: self-checking bench for the triggered delay pulse timer
// Assumes: 125 MHz clock, tick of 125 cycles, bus master in this module
// Notes: pulse windows allow one tick of phase slack
`timescale 1ns/1ps
`include "tdpt_regs.vh"
module tb_triggered_delay_pulse_timer;
   logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0]  src = 4'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   wire         pin_out, tos, awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          n_errors = 0, checked = 0, seed = 58, width, pulses, t, o, c, dl, ln;
   int          mdl[int] = '{'h00:0, 'h04:0, 'h08:0, 'h0C:0, 'h10:1, 'h20:0};
   int          pv[6] = '{'h23, 'h33, 'h10, 'h02, 'h15, 'h00};
   logic [31:0] d;
   always #4 clk = ~clk;
   tdpt_top tdpt_top_inst (.clk(clk), .rst_n(rst_n), .exposure_window(src[0]), .readout_window(src[1]),
      .external_trigger_input(src[2]), .counter_output(src[3]), .pin_out(pin_out), .timer_output_source(tos),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   tdpt_partner tdpt_partner_inst (.clk(clk), .line_in(pin_out), .width(width), .pulses(pulses));
   // ==========================================
   // compare and bus tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
      checked++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask
   function automatic int lim(int a, int v);
      if (a == 'h10 && v < 1) return 1;
      if ((a == 'h10 || a == 'h0C) && v > 60000000) return 60000000;
      return v;
   endfunction
   // expected line level for a pin setting, from the current camera levels
   function automatic logic pexp(int p);
      logic s;
      case (p & 7)
         1: s = src[1];
         2: s = src[0];
         3: s = p[5];
         5: s = src[3];
         default: s = 1'b0;
      endcase
      return s ^ p[4];
   endfunction
   task automatic wr(input [7:0] a, input [31:0] v, input [1:0] er);
      int k;
      k = 0;
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk);
         k++;
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!(bvalid && bready) && k < 50);
      chk("bresp", {1'b1, er}, {bvalid, bresp});
      if (er == 0 && mdl.exists(a)) mdl[a] = lim(a, v);
      bready <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input [7:0] a, input [1:0] er, output logic [31:0] v);
      int k;
      k = 0;
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk);
         k++;
         if (arvalid && arready) arvalid <= 0;
      end while (!(rvalid && rready) && k < 50);
      chk("rresp", {1'b1, er}, {rvalid, rresp});
      v = rdata;
      rready <= 0;
      @(posedge clk);
   endtask
   task automatic wait_pin(input logic lv);
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pin_out !== lv && t < 9000);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #800000;
      n_errors++;
      print_verdict();
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      foreach (mdl[a]) begin
         rd(a, 0, d);
         chk("reset cfg", mdl[a], d);
      end
      rd(`TDPT_OFF_STATE, 0, d); chk("state", `TDPT_ST_IDLE, d);
      rd(8'h24, 2, d);
      wr(`TDPT_OFF_PICK, 1, 2);
      wr(`TDPT_OFF_PICK, 0, 0);
      wr(`TDPT_OFF_PIN, `TDPT_PIN_TIMER, 0);
      src <= 4'hF;
      repeat (20) @(posedge clk);
      src <= 4'h0;
      repeat (300) @(posedge clk);
      rd(`TDPT_OFF_STATE, 0, d); chk("off state", `TDPT_ST_IDLE, d);
      chk("off pulses", 0, pulses);
      for (c = 0; c < 3; c++) begin
         for (o = 1; o < 5; o++) begin
            dl = {$random(seed)} % 3;
            ln = 1 + {$random(seed)} % 3;
            wr(`TDPT_OFF_ORIGIN, 0, 0);
            src <= (c == 1) ? 4'hF : 4'h0;
            wr(`TDPT_OFF_COND, c, 0);
            wr(`TDPT_OFF_DELAY, dl, 0);
            wr(`TDPT_OFF_LENGTH, ln, 0);
            wr(`TDPT_OFF_ORIGIN, o, 0);
            rd(`TDPT_OFF_STATE, 0, d); chk("armed", `TDPT_ST_WAIT, d);
            src[o-1] <= ~src[o-1];
            wait_pin(1);
            chk_rng("delay", dl * 125, dl * 125 + 130, t);
            chk("timer out", 1, tos);
            wait_pin(0);
            @(posedge clk);
            chk_rng("width", ln * 125 - 124, ln * 125 + 125, width);
            rd(`TDPT_OFF_STATE, 0, d); chk("rearmed", `TDPT_ST_WAIT, d);
         end
      end
      for (c = 3; c < 5; c++) begin
         o = 1 + {$random(seed)} % 4;
         wr(`TDPT_OFF_ORIGIN, 0, 0);
         src <= (c == 4) ? 4'hF : 4'h0;
         wr(`TDPT_OFF_COND, c, 0);
         wr(`TDPT_OFF_DELAY, 1, 0);
         wr(`TDPT_OFF_ORIGIN, o, 0);
         src[o-1] <= ~src[o-1];
         wait_pin(1);
         chk_rng("level delay", 125, 255, t);
         repeat (600) @(posedge clk);
         chk("level hold", 1, pin_out);
         src[o-1] <= ~src[o-1];
         repeat (6) @(posedge clk);
         chk("level drop", 0, pin_out);
      end
      // long pulse cut short by a restart
      wr(`TDPT_OFF_ORIGIN, 0, 0);
      src <= 4'h0;
      wr(`TDPT_OFF_COND, `TDPT_CND_EUP, 0);
      wr(`TDPT_OFF_DELAY, 0, 0);
      wr(`TDPT_OFF_LENGTH, 1000, 0);
      wr(`TDPT_OFF_ORIGIN, `TDPT_ORG_EXPO, 0);
      src[0] <= 1;
      repeat (420) @(posedge clk);
      rd(`TDPT_OFF_COUNT, 0, d); chk("count", 1, d >= 2 && d <= 4);
      chk("running", 1, tos);
      wr(`TDPT_OFF_RESTART, 1, 0);
      // the output register settles one edge after the state leaves the pulse
      @(posedge clk);
      chk("restart out", 0, tos);
      rd(`TDPT_OFF_STATE, 0, d); chk("restart state", `TDPT_ST_WAIT, d);
      rd(`TDPT_OFF_COUNT, 0, d); chk("restart count", 0, d);
      foreach (pv[i]) begin
         wr(`TDPT_OFF_PIN, pv[i], 0);
         repeat (3) @(posedge clk);
         chk("pin level", pexp(pv[i]), pin_out);
      end
      wr(`TDPT_OFF_LENGTH, 0, 0);
      wr(`TDPT_OFF_DELAY, 60000001, 0);
      foreach (mdl[a]) begin
         rd(a, 0, d);
         chk("cfg", mdl[a], d);
      end
      print_verdict();
   end
endmodule
